/* File: shared/faa_pkg.sv */
// Package for the flash access arbiter: widths, counts and enumerations
package faa_pkg;
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned RAM_BLOCKS = 4;
  localparam int unsigned BLK_ADDR_W = 8;
  localparam logic [BLK_ADDR_W-1:0] BLK_LAST = 8'hff;
  localparam int unsigned BLK_IDX_W = 2;
  localparam logic [BLK_IDX_W-1:0] BLK_IDX_LAST = 2'h3;
  localparam logic [ADDR_W-1:0] INIT_BASE = 18'h00000;
  localparam logic [ADDR_W-1:0] SAVE_BASE = 18'h00000;
  // Cycle counts at 250 MHz; user clock limit stated in MHz
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned USER_MAX_MHZ = 100;
  localparam int unsigned FLASH_LAT_NS = 40;
  localparam int unsigned FLASH_LAT_CYC = (FLASH_LAT_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] FLASH_LAT = 4'(FLASH_LAT_CYC);
  typedef enum logic [1:0] {FAA_OWN_USER, FAA_OWN_ENGINE} faa_owner_t;
endpackage

/* File: shared/faa_flash_if.sv */
// Flash request channel shared between the arbiter and the engine
`timescale 1ns/100ps
interface faa_flash_if;
  logic req;
  logic we;
  logic [faa_pkg::ADDR_W-1:0] addr;
  logic [faa_pkg::DATA_W-1:0] wdata;
  logic ack;
  logic [faa_pkg::DATA_W-1:0] rdata;
  modport engine (output req, output we, output addr, output wdata, input ack, input rdata);
  modport arb (input req, input we, input addr, input wdata, output ack, output rdata);
endinterface

/* File: core/faa_boot_loader_engine.sv */
// Boot loader engine: power-up load of each RAM block and save requests
`timescale 1ns/100ps
module faa_boot_loader_engine (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic save_req,
  faa_flash_if.engine fl,
  output logic busy,
  output logic ram_we,
  output logic [faa_pkg::BLK_IDX_W-1:0] ram_sel,
  output logic [faa_pkg::BLK_ADDR_W-1:0] ram_addr,
  output logic [faa_pkg::DATA_W-1:0] ram_wdata,
  output logic [faa_pkg::BLK_ADDR_W-1:0] save_raddr,
  input wire logic [faa_pkg::DATA_W-1:0] save_rdata
);
  typedef enum logic [1:0] {FAA_ST_INIT, FAA_ST_IDLE, FAA_ST_SAVE} faa_st_t;
  faa_st_t st_q;
  logic [faa_pkg::BLK_IDX_W-1:0] blk_q;
  logic [faa_pkg::BLK_ADDR_W-1:0] wa_q;
  logic pend_q;
  logic last_word;
  assign last_word = (wa_q == faa_pkg::BLK_LAST);
  assign busy = (st_q != FAA_ST_IDLE);
  // ==========================================
  // Sequencing
  // Init starts straight out of reset with no request
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      st_q <= FAA_ST_INIT;
      blk_q <= '0;
      wa_q <= '0;
      pend_q <= 1'b0;
      ram_we <= 1'b0;
    end else begin
      ram_we <= 1'b0;
      pend_q <= pend_q & ~fl.ack;
      case (st_q)
        FAA_ST_INIT: begin
          if (!pend_q) begin
            pend_q <= 1'b1;
          end else if (fl.ack) begin
            ram_we <= 1'b1;
            wa_q <= wa_q + 1'b1;
            if (last_word) begin
              // One client per cascaded block
              blk_q <= blk_q + 1'b1;
              if (blk_q == faa_pkg::BLK_IDX_LAST) begin
                st_q <= FAA_ST_IDLE;
              end
            end
          end
        end
        FAA_ST_IDLE: begin
          if (save_req) begin
            st_q <= FAA_ST_SAVE;
            wa_q <= '0;
          end
        end
        FAA_ST_SAVE: begin
          if (!pend_q) begin
            pend_q <= 1'b1;
          end else if (fl.ack) begin
            wa_q <= wa_q + 1'b1;
            if (last_word) begin
              st_q <= FAA_ST_IDLE;
            end
          end
        end
        default: st_q <= FAA_ST_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ram_sel <= '0;
      ram_addr <= '0;
      ram_wdata <= '0;
    end else if (fl.ack && st_q == FAA_ST_INIT) begin
      ram_sel <= blk_q;
      ram_addr <= wa_q;
      ram_wdata <= fl.rdata;
    end
  end
  assign fl.req = pend_q & busy;
  assign fl.we = (st_q == FAA_ST_SAVE);
  assign fl.addr = (st_q == FAA_ST_SAVE) ?
    faa_pkg::SAVE_BASE + faa_pkg::ADDR_W'(wa_q) :
    faa_pkg::INIT_BASE + faa_pkg::ADDR_W'({blk_q, wa_q});
  assign fl.wdata = save_rdata;
  assign save_raddr = wa_q;
endmodule

/* File: core/faa_flash_arbiter.sv */
// Flash access arbiter: engine versus user data-storage port
`timescale 1ns/100ps
// Functional notes
// - At power-up the engine loads RAM from flash with no user request.
// - A cascaded RAM gets one init client per block so each block loads.
// - Fixed priority gives the flash to the engine whenever init or save runs.
// - Engine and user sides share one clock input of the flash block.
module faa_flash_arbiter (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic user_req,
  input wire logic user_we,
  input wire logic [faa_pkg::ADDR_W-1:0] user_addr,
  input wire logic [faa_pkg::DATA_W-1:0] user_wdata,
  output logic user_ack,
  output logic [faa_pkg::DATA_W-1:0] user_rdata,
  input wire logic save_req,
  output logic engine_complete_flag,
  output logic ram_we,
  output logic [faa_pkg::BLK_IDX_W-1:0] ram_sel,
  output logic [faa_pkg::BLK_ADDR_W-1:0] ram_addr,
  output logic [faa_pkg::DATA_W-1:0] ram_wdata,
  output logic [faa_pkg::BLK_ADDR_W-1:0] save_raddr,
  input wire logic [faa_pkg::DATA_W-1:0] save_rdata,
  output logic flash_req,
  output logic flash_we,
  output logic [faa_pkg::ADDR_W-1:0] flash_addr,
  output logic [faa_pkg::DATA_W-1:0] flash_wdata,
  input wire logic flash_ack,
  input wire logic [faa_pkg::DATA_W-1:0] flash_rdata
);
  // ==========================================
  // Engine
  // Single clk_sys serves both engine and user sides
  faa_flash_if fl ();
  logic eng_busy;
  logic eng_ram_we;
  logic [faa_pkg::BLK_IDX_W-1:0] eng_sel;
  logic [faa_pkg::BLK_ADDR_W-1:0] eng_addr;
  logic [faa_pkg::DATA_W-1:0] eng_wdata;
  logic [faa_pkg::BLK_ADDR_W-1:0] eng_raddr;
  faa_boot_loader_engine faa_boot_loader_engine_i (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .save_req(save_req),
    .fl(fl.engine),
    .busy(eng_busy),
    .ram_we(eng_ram_we),
    .ram_sel(eng_sel),
    .ram_addr(eng_addr),
    .ram_wdata(eng_wdata),
    .save_raddr(eng_raddr),
    .save_rdata(save_rdata)
  );
  // ==========================================
  // Ownership
  faa_pkg::faa_owner_t own_q;
  logic inflight_q;
  logic grant_user;
  // Owner only changes with no flash access in flight or on the flash_ack ending it, avoiding torn cycles
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      own_q <= faa_pkg::FAA_OWN_ENGINE;
    end else if (!inflight_q || flash_ack) begin
      own_q <= eng_busy ? faa_pkg::FAA_OWN_ENGINE : faa_pkg::FAA_OWN_USER;
    end
  end
  // User gated whenever engine is busy or owns
  assign grant_user = (own_q == faa_pkg::FAA_OWN_USER) && !eng_busy;
  // ==========================================
  // Flash request registers
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      inflight_q <= 1'b0;
      flash_req <= 1'b0;
      flash_we <= 1'b0;
      flash_addr <= '0;
      flash_wdata <= '0;
    end else if (inflight_q) begin
      if (flash_ack) begin
        inflight_q <= 1'b0;
        flash_req <= 1'b0;
      end
    end else if (own_q == faa_pkg::FAA_OWN_ENGINE && fl.req && !fl.ack) begin
      inflight_q <= 1'b1;
      flash_req <= 1'b1;
      flash_we <= fl.we;
      flash_addr <= fl.addr;
      flash_wdata <= fl.wdata;
    end else if (grant_user && user_req && !user_ack) begin
      inflight_q <= 1'b1;
      flash_req <= 1'b1;
      flash_we <= user_we;
      flash_addr <= user_addr;
      flash_wdata <= user_wdata;
    end
  end
  // ==========================================
  // Answers
  logic eng_txn_q;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      eng_txn_q <= 1'b0;
    end else if (!inflight_q) begin
      eng_txn_q <= (own_q == faa_pkg::FAA_OWN_ENGINE);
    end
  end
  assign fl.ack = inflight_q && flash_ack && eng_txn_q;
  assign fl.rdata = flash_rdata;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      user_ack <= 1'b0;
      user_rdata <= '0;
    end else begin
      user_ack <= inflight_q && flash_ack && !eng_txn_q;
      if (inflight_q && flash_ack && !eng_txn_q) begin
        user_rdata <= flash_rdata;
      end
    end
  end
  // ==========================================
  // Status and RAM port
  // Flag drops as soon as a save is accepted, so user may release it
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      engine_complete_flag <= 1'b0;
    end else begin
      engine_complete_flag <= !eng_busy && !save_req;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ram_we <= 1'b0;
      ram_sel <= '0;
      ram_addr <= '0;
      ram_wdata <= '0;
      save_raddr <= '0;
    end else begin
      ram_we <= eng_ram_we;
      ram_sel <= eng_sel;
      ram_addr <= eng_addr;
      ram_wdata <= eng_wdata;
      save_raddr <= eng_raddr;
    end
  end
endmodule

/* File: bench/faa_asserts.sv */
// Port checker for the flash access arbiter
`timescale 1ns/100ps
module faa_asserts (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic user_ack,
  input wire logic save_req,
  input wire logic engine_complete_flag,
  input wire logic ram_we,
  input wire logic flash_req,
  input wire logic flash_ack,
  input wire logic [faa_pkg::ADDR_W-1:0] flash_addr
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  // ==========================================
  // Properties
  a_boot_load_start: assert property ($rose(rst_b) |-> ##[0:4] flash_req)
    else $error("no flash load after reset");
  a_ram_load_busy: assert property (ram_we |-> !$past(engine_complete_flag))
    else $error("ram write while idle");
  a_save_takes_own: assert property (engine_complete_flag && save_req |=> !engine_complete_flag)
    else $error("save did not take ownership");
  a_ack_after_flash: assert property (user_ack |-> $past(flash_ack))
    else $error("user ack without flash ack");
  a_busy_no_ack: assert property (!engine_complete_flag && !flash_req |-> ##2 !user_ack)
    else $error("user served while engine owns");
  a_req_held: assert property (flash_req && !flash_ack |=> flash_req && $stable(flash_addr))
    else $error("flash request dropped early");
  c_ram_load: cover property (ram_we);
  c_user_ack: cover property (user_ack);
  c_save: cover property (engine_complete_flag && save_req);
endmodule
bind faa_flash_arbiter faa_asserts faa_asserts_i (.clk_sys, .rst_b, .user_ack, .save_req,
  .engine_complete_flag, .ram_we, .flash_req, .flash_ack, .flash_addr);

/* File: bench/faa_flash_model.sv */
// Behavioural flash memory on the arbiter's far side
`timescale 1ns/100ps
module faa_flash_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic slow,
  input wire logic flash_req,
  input wire logic flash_we,
  input wire logic [faa_pkg::ADDR_W-1:0] flash_addr,
  input wire logic [faa_pkg::DATA_W-1:0] flash_wdata,
  output logic flash_ack,
  output logic [faa_pkg::DATA_W-1:0] flash_rdata
);
  logic [31:0] mem [logic [17:0]];
  logic [3:0] cnt_q;
  // ==========================================
  // Access timing
  // Idle data toggles so a stale read never matches
  // At best one access per five clocks, so the user rate stays under the limit
  always @(posedge clk_sys) begin
    flash_ack <= 1'b0;
    flash_rdata <= rst_b ? ~flash_rdata : 32'h0;
    cnt_q <= 4'h0;
    if (rst_b && flash_req && !flash_ack) begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q >= (slow ? 4'h9 : 4'h1)) begin
        flash_ack <= 1'b1;
        if (flash_we) mem[flash_addr] = flash_wdata;
        flash_rdata <= mem.exists(flash_addr) ? mem[flash_addr] : 32'(flash_addr) ^ 32'h5a5a0000;
      end
    end
  end
endmodule

/* File: bench/faa_flash_arbiter_bench.sv */
// Self-checking bench for the flash access arbiter
`timescale 1ns/100ps
module faa_flash_arbiter_bench;
  localparam logic [31:0] SAVE_D = 32'hc3c33c3c;
  typedef struct {logic w; logic [17:0] a; logic [31:0] d; logic [31:0] e;} faa_row_t;
  faa_row_t rows [4] = '{'{1'b1, 18'h30000, 32'h1234abcd, 32'h0},
    '{1'b0, 18'h30000, 32'h0, 32'h1234abcd}, '{1'b0, 18'h30001, 32'h0, 32'h5a590001},
    '{1'b0, 18'h3ffff, 32'h0, 32'h5a59ffff}};
  logic clk_sys, rst_b, user_req, user_we, user_ack, save_req, slow, saved;
  logic engine_complete_flag, ram_we, flash_req, flash_we, flash_ack;
  logic [1:0] ram_sel;
  logic [7:0] ram_addr, save_raddr;
  logic [17:0] user_addr, flash_addr;
  logic [31:0] user_wdata, user_rdata, ram_wdata, save_rdata, flash_wdata, flash_rdata, q;
  int error_cnt, n_compared, n;
  int loads [4];
  faa_flash_arbiter faa_flash_arbiter_i (.clk_sys, .rst_b, .user_req, .user_we, .user_addr,
    .user_wdata, .user_ack, .user_rdata, .save_req, .engine_complete_flag, .ram_we, .ram_sel,
    .ram_addr, .ram_wdata, .save_raddr, .save_rdata, .flash_req, .flash_we, .flash_addr,
    .flash_wdata, .flash_ack, .flash_rdata);
  faa_flash_model faa_flash_model_i (.clk_sys, .rst_b, .slow, .flash_req, .flash_we,
    .flash_addr, .flash_wdata, .flash_ack, .flash_rdata);
  // Save source RAM read port: word index folded in so a misaligned save shows
  assign save_rdata = SAVE_D ^ 32'(save_raddr);
  // ==========================================
  // Helpers
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic test_done;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wait_done;
    for (n = 0; n < 30000 && engine_complete_flag !== 1'b1; n++) @(negedge clk_sys);
    chk("flag", 1'b1, engine_complete_flag);
    // Last RAM write lands with the flag; let the monitor count it first
    @(negedge clk_sys);
    for (int i = 0; i < 4; i++) chk("loads", 256, loads[i]);
    @(posedge clk_sys);
  endtask
  task automatic xfer(input logic w, input logic [17:0] a, input logic [31:0] d);
    user_we <= w;
    user_addr <= a;
    user_wdata <= d;
    user_req <= 1'b1;
    for (n = 0; n < 30000 && user_ack !== 1'b1; n++) @(negedge clk_sys);
    chk("user_ack", 1'b1, user_ack);
    q = user_rdata;
    @(posedge clk_sys);
    user_req <= 1'b0;
    @(posedge clk_sys);
  endtask
  // Loaded words: block 0 holds saved data once a save has run
  always @(negedge clk_sys) begin
    if (rst_b === 1'b1 && ram_we === 1'b1) begin
      loads[ram_sel]++;
      chk("ram_wdata", (saved && ram_sel == 2'h0) ? SAVE_D ^ 32'(ram_addr) :
        32'(faa_pkg::INIT_BASE + 18'({ram_sel, ram_addr})) ^ 32'h5a5a0000, ram_wdata);
    end
  end
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    #200000;
    error_cnt++;
    test_done;
  end
  // ==========================================
  // Sequence
  initial begin
    {rst_b, user_req, user_we, save_req, slow, saved} = 6'h0;
    user_addr = 18'h0;
    user_wdata = 32'h0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    wait_done;
    foreach (rows[i]) begin
      xfer(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk("user_rdata", rows[i].e, q);
    end
    slow <= 1'b1;
    save_req <= 1'b1;
    for (n = 0; n < 100 && engine_complete_flag !== 1'b0; n++) @(negedge clk_sys);
    chk("flag_low", 1'b0, engine_complete_flag);
    @(posedge clk_sys);
    save_req <= 1'b0;
    saved <= 1'b1;
    xfer(1'b0, 18'h00005, 32'h0);
    chk("save_word", SAVE_D ^ 32'h00000005, q);
    loads = '{0, 0, 0, 0};
    rst_b <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk("rst_flag", 1'b0, engine_complete_flag);
    @(posedge clk_sys);
    rst_b <= 1'b1;
    wait_done;
    test_done;
  end
endmodule
